//--- hdl/sfhi_pkg.sv
// Shared constants for the serial flash front end and its host controller.
// Assumes pclk at 40 MHz; the link clock is slower and sampled by pclk.
// What this block does
// - Single lane samples input on clock rise
// - Single lane drives output on clock fall
// - Clock modes 0 and 3 only
// - Dual opcodes use lanes 0 and 1
// - Quad opcodes use all four lanes
// - Quad opcodes run only with quad_lane_enable
// - Opcode 38h enters four-lane opcode mode
// - Opcode FFh leaves four-lane opcode mode
// - Power-up and soft reset give SPI mode
// - Four-lane mode entry needs quad_lane_enable
// - Pause only without quad_lane_enable
// - Pause starts on pin fall, clock low
// - Pause ends on pin rise, clock low
// - Paused: outputs off, inputs ignored, state kept
// - Host keeps select low through pause
// - Soft reset is 66h then 99h
// - Soft reset takes 30 us, commands refused
// - Config bit picks pause or reset pin
// - Reset pin low 1 us resets all
// - No command while reset pin low
// - quad_lane_enable disables pause and reset pin
// - Dedicated reset pin overrides everything
// - Deselected outputs off; select high arms
package sfhi_pkg;
  // Timing
  localparam int CLK_NS     = 25;                          // pclk period
  localparam int LINK_NS    = 200;                         // Serial clock period
  localparam int LINK_HALF  = LINK_NS / (2 * CLK_NS);      // pclk per half period
  localparam int SW_RST_NS  = 30000;                       // Soft reset time
  localparam int SW_RST_CYC = (SW_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int HW_RST_NS  = 1000;                        // hw_reset_min_pulse
  localparam int HW_RST_CYC = (HW_RST_NS + CLK_NS - 1) / CLK_NS;
  // Opcodes
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO   = 8'heb;
  localparam logic [7:0] OP_WORD_QIO  = 8'he7;
  localparam logic [7:0] OP_OCT_QIO   = 8'he3;
  localparam logic [7:0] OP_FCM_ENTER = 8'h38;
  localparam logic [7:0] OP_FCM_EXIT  = 8'hff;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  // Lane width code, log2 of bits per clock
  localparam logic [1:0] LW1 = 2'h0;
  localparam logic [1:0] LW2 = 2'h1;
  localparam logic [1:0] LW4 = 2'h2;
  // Synchroniser reset: rst_n, cs_n high, sck low, lanes high
  localparam logic [6:0] SYNC_RST = 7'h6f;
  // Host APB map
  localparam int          APB_AW  = 12;
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_TXD   = 12'h004;
  localparam logic [11:0] A_RXD   = 12'h008;
  localparam logic [11:0] A_STAT  = 12'h00c;
  localparam logic [11:0] A_PAUSE = 12'h010;
  localparam logic [11:0] A_HWRST = 12'h014;
  // Control field layout
  localparam int CT_LANE = 8;   // [9:8] lane code
  localparam int CT_RD   = 10;  // Read direction
  localparam int CT_FCM  = 11;  // Opcode on four lanes
  localparam int CT_NB   = 12;  // [14:12] data bytes
  localparam int CT_TOP  = 14;
  localparam logic [2:0] NB_MAX = 3'h4;
  // States
  typedef enum logic [3:0] {
    DS_IDLE = 4'b0001, DS_OPC = 4'b0010, DS_DATA = 4'b0100, DS_IGN = 4'b1000
  } sfhi_dst_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001, HS_SEL = 4'b0010, HS_XFER = 4'b0100, HS_END = 4'b1000
  } sfhi_hst_t;
endpackage

//--- hdl/sfhi_if.sv
// Link wires between the flash front end and its host controller.
// Assumes both ends share pclk; undriven lanes float high.
`timescale 1ns/1ps
interface sfhi_if;
  logic       sck;   // Serial clock from host
  logic       cs_n;  // Chip select
  logic       rst_n; // Dedicated reset pin
  logic [3:0] h_o;   // Host lane drive
  logic [3:0] h_oe;  // Host lane enable
  logic [3:0] d_o;   // Device lane drive
  logic [3:0] d_oe;  // Device lane enable
  logic [3:0] io;    // Resolved lane level
  // Pull-up on every lane; clashes resolve as wired-or
  assign io = (h_oe & h_o) | (d_oe & d_o) | ~(h_oe | d_oe);
  modport host (output sck, cs_n, rst_n, h_o, h_oe, input io);
  modport dev (input sck, cs_n, rst_n, io, output d_o, d_oe);
endinterface

//--- hdl/sfhi_dev.sv
// Flash end of the link: framing, lane modes, pause and resets.
// Assumes core logic on pclk supplies read bytes and takes received ones.
`timescale 1ns/1ps
module sfhi_dev
#(
  parameter int RST_CYC = sfhi_pkg::SW_RST_CYC
)
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Link
  sfhi_if.dev             lnk,
  // Configuration bits
  input  wire logic       quad_lane_enable,
  input  wire logic       pin_is_reset,
  // Received bytes
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_is_opc,
  // Bytes to send
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_drive,
  output logic            tx_taken,
  // State
  output logic            four_lane_command_mode,
  output logic            paused,
  output logic            busy
);
  import sfhi_pkg::*;

  localparam int BW = $clog2(RST_CYC + 1);

  if (RST_CYC < 1)
  begin : g_chk
    $error("RST_CYC must be at least one");
  end

  logic [6:0]    s1_q;      // First sync stage
  logic [6:0]    s2_q;      // Second sync stage
  logic [6:0]    s3_q;      // Edge history
  logic [3:0]    io_s;      // Lanes
  logic          sck_s;     // Serial clock
  logic          cs_n_s;    // Select
  logic          hw_rst;    // Any hardware reset
  logic          hold_fn;   // Shared pin is pause
  logic          rise;      // Clock rise seen
  logic          fall;      // Clock fall seen
  logic          act;       // Not paused or reset
  logic          pause_q;   // Pause in force
  logic          armed_q;   // Select seen high
  logic          fcm_q;     // Four-lane opcode mode
  logic          rst_en_q;  // Reset enable latched
  logic [BW-1:0] bcnt_q;    // Soft reset countdown
  sfhi_dst_t     st_q;      // Frame state
  logic [1:0]    lw_q;      // Lane width code
  logic [2:0]    cnt_q;     // Clocks in byte
  logic [7:0]    sh_q;      // Input shifter
  logic [7:0]    sh_nx;     // Shifter after edge
  logic          last;      // Final clock of byte
  logic          take;      // Accepted rise
  logic          opc_done;  // Opcode complete
  logic          is_quad;   // Quad opcode
  logic          is_dual;   // Dual opcode
  logic          is_one;    // Opcode-only command
  logic          put;       // Accepted fall
  logic [7:0]    tx_cur;    // Byte being sent
  logic [7:0]    osh_q;     // Output shifter
  logic [3:0]    do_q;      // Lane drive
  logic [3:0]    oe_q;      // Lane enable

  // Two flops before any pin is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end
    else
    begin
      s1_q <= {lnk.rst_n, lnk.cs_n, lnk.sck, lnk.io};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign io_s    = s2_q[3:0];
  assign sck_s   = s2_q[4];
  assign cs_n_s  = s2_q[5];
  // Either edge polarity at select is fine, so both modes work
  assign rise    = sck_s & ~s3_q[4];
  assign fall    = ~sck_s & s3_q[4];
  assign hold_fn = ~quad_lane_enable & ~pin_is_reset;
  // Dedicated pin always acts; shared pin only as configured
  assign hw_rst  = ~s2_q[6] | (pin_is_reset & ~quad_lane_enable & ~io_s[3]);
  assign act     = ~pause_q & ~hw_rst & ~cs_n_s;
  assign busy    = bcnt_q != '0;

  // Pause follows the pin only while the clock sits low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pause_q <= 1'b0;
    else if (!hold_fn || cs_n_s || hw_rst)
      pause_q <= 1'b0;
    else if (!sck_s)
      pause_q <= ~io_s[3];
  end

  // Input shift by lane width, MSB first
  always_comb
  begin
    case (lw_q)
      LW2:     sh_nx = {sh_q[5:0], io_s[1:0]};
      LW4:     sh_nx = {sh_q[3:0], io_s};
      default: sh_nx = {sh_q[6:0], io_s[0]};
    endcase
  end

  assign last     = cnt_q == (3'h7 >> lw_q);
  assign take     = rise & act & (st_q == DS_OPC || st_q == DS_DATA);
  assign opc_done = take & last & (st_q == DS_OPC);
  assign is_quad  = sh_nx == OP_QUAD_OUT || sh_nx == OP_QUAD_IO ||
                    sh_nx == OP_WORD_QIO || sh_nx == OP_OCT_QIO;
  assign is_dual  = sh_nx == OP_DUAL_OUT || sh_nx == OP_DUAL_IO;
  assign is_one   = sh_nx == OP_RST_EN || sh_nx == OP_RST ||
                    sh_nx == OP_FCM_ENTER || sh_nx == OP_FCM_EXIT;

  // Mode, reset sequence and arming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fcm_q    <= 1'b0;
      rst_en_q <= 1'b0;
      bcnt_q   <= '0;
      armed_q  <= 1'b0;
    end
    else if (hw_rst)
    begin
      // Back to power-on state, any running wait aborted
      fcm_q    <= 1'b0;
      rst_en_q <= 1'b0;
      bcnt_q   <= '0;
      armed_q  <= 1'b0;
    end
    else
    begin
      if (cs_n_s)
        armed_q <= 1'b1;
      if (busy)
        bcnt_q <= bcnt_q - 1'b1;
      if (bcnt_q == BW'(1))
        fcm_q <= 1'b0;
      if (opc_done)
      begin
        rst_en_q <= sh_nx == OP_RST_EN;
        if (sh_nx == OP_RST && rst_en_q)
          bcnt_q <= BW'(RST_CYC);
        else if (sh_nx == OP_FCM_ENTER && quad_lane_enable)
          fcm_q <= 1'b1;
        else if (sh_nx == OP_FCM_EXIT && fcm_q)
          fcm_q <= 1'b0;
      end
    end
  end

  // Frame sequencing; deselect drops the partial command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= DS_IDLE;
      lw_q  <= LW1;
      cnt_q <= 3'h0;
      sh_q  <= 8'h00;
    end
    else if (hw_rst || cs_n_s)
    begin
      st_q  <= DS_IDLE;
      cnt_q <= 3'h0;
    end
    else
    begin
      case (st_q)
        DS_IDLE:
        begin
          // Refused frames run to deselect untouched
          st_q <= (armed_q && !busy) ? DS_OPC : DS_IGN;
          lw_q <= fcm_q ? LW4 : LW1;
        end
        DS_OPC, DS_DATA:
        begin
          if (take)
          begin
            sh_q  <= sh_nx;
            cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
            if (opc_done)
            begin
              if (is_one)
                st_q <= DS_IGN;
              else if (is_quad && !fcm_q)
              begin
                st_q <= quad_lane_enable ? DS_DATA : DS_IGN;
                lw_q <= LW4;
              end
              else if (is_dual && !fcm_q)
              begin
                st_q <= DS_DATA;
                lw_q <= LW2;
              end
              else
                st_q <= DS_DATA;
            end
          end
        end
        DS_IGN:
          st_q <= DS_IGN;
        default:
          st_q <= DS_IDLE;
      endcase
    end
  end

  // Hand received bytes to the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_byte   <= 8'h00;
      rx_valid  <= 1'b0;
      rx_is_opc <= 1'b0;
    end
    else
    begin
      rx_valid <= take & last;
      if (take && last)
      begin
        rx_byte   <= sh_nx;
        rx_is_opc <= st_q == DS_OPC;
      end
    end
  end

  // Output path; a byte starts at the first fall after a byte boundary
  assign tx_cur = (cnt_q == 3'h0) ? tx_byte : osh_q;
  assign put    = fall & act & tx_drive & (st_q == DS_DATA);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osh_q    <= 8'h00;
      do_q     <= 4'h0;
      oe_q     <= 4'h0;
      tx_taken <= 1'b0;
    end
    else
    begin
      tx_taken <= put & (cnt_q == 3'h0);
      if (cs_n_s || hw_rst || st_q != DS_DATA || !tx_drive)
        oe_q <= 4'h0;
      else if (put)
      begin
        case (lw_q)
          LW2:
          begin
            do_q  <= {2'h0, tx_cur[7:6]};
            osh_q <= {tx_cur[5:0], 2'h0};
            oe_q  <= 4'h3;
          end
          LW4:
          begin
            do_q  <= tx_cur[7:4];
            osh_q <= {tx_cur[3:0], 4'h0};
            oe_q  <= 4'hf;
          end
          default:
          begin
            do_q  <= {2'h0, tx_cur[7], 1'b0};
            osh_q <= {tx_cur[6:0], 1'b0};
            oe_q  <= 4'h2;
          end
        endcase
      end
    end
  end

  // Select high or pause releases the lanes at once
  assign lnk.d_o  = do_q;
  assign lnk.d_oe = (pause_q || cs_n_s) ? 4'h0 : oe_q;

  assign four_lane_command_mode = fcm_q;
  assign paused                 = pause_q;
endmodule

//--- hdl/sfhi_host.sv
// Host controller end: runs one framed command per control write.
// Assumes software on APB; serial clock made by dividing pclk, mode 0.
`timescale 1ns/1ps
module sfhi_host
#(
  parameter int SCK_HALF = sfhi_pkg::LINK_HALF
)
(
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sfhi_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Link
  sfhi_if.host                             lnk
);
  import sfhi_pkg::*;

  localparam int DW = $clog2(SCK_HALF);
  localparam int RW = $clog2(HW_RST_CYC + 1);

  // Sampling at end of high phase needs sync plus device latency
  if (SCK_HALF < 4)
  begin : g_chk
    $error("SCK_HALF below 4 cannot meet read sampling");
  end

  logic [7:0]    opc_q;   // Opcode
  logic [1:0]    lane_q;  // Data lane code
  logic          rd_q;    // Data phase reads
  logic          fcm_q;   // Opcode on four lanes
  logic [2:0]    nb_q;    // Data bytes
  logic [31:0]   txd_q;   // Bytes to send
  logic [31:0]   rxd_q;   // Bytes read
  logic          pause_q; // Pause request
  logic [RW-1:0] rcnt_q;  // Reset pulse count
  sfhi_hst_t     st_q;    // Frame state
  logic [DW-1:0] div_q;   // Half-period divider
  logic          tick;    // Half-period enable
  logic          sck_q;   // Serial clock
  logic          cs_n_q;  // Select
  logic [5:0]    ccnt_q;  // Clocks done
  logic [5:0]    opcl;    // Opcode clocks
  logic [5:0]    ncl;     // Frame clocks
  logic          in_dat;  // Past the opcode
  logic [1:0]    hl;      // Current lane code
  logic [39:0]   tsh_q;   // Output shifter
  logic [3:0]    s1_q;    // Lane sync stage 1
  logic [3:0]    s2_q;    // Lane sync stage 2
  logic          wr;      // APB write access
  logic          go;      // Frame start
  logic          hit;     // Mapped address
  logic [3:0]    ho;      // Lane drive
  logic [3:0]    hoe;     // Lane enable

  assign wr     = psel & penable & pwrite;
  assign go     = wr && paddr == A_CTRL && st_q == HS_IDLE && rcnt_q == '0 &&
                  pwdata[CT_TOP:CT_NB] <= NB_MAX;
  assign pready = 1'b1;

  // Register read mux, unmapped reads flag an error
  always_comb
  begin
    hit    = 1'b1;
    prdata = 32'h0;
    case (paddr)
      A_CTRL:  prdata = {17'h0, nb_q, fcm_q, rd_q, lane_q, opc_q};
      A_TXD:   prdata = txd_q;
      A_RXD:   prdata = rxd_q;
      A_STAT:  prdata = {30'h0, rcnt_q != '0, st_q != HS_IDLE};
      A_PAUSE: prdata = {31'h0, pause_q};
      A_HWRST: prdata = 32'h0;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // Software-written settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {nb_q, fcm_q, rd_q, lane_q, opc_q} <= 15'h0;
      txd_q   <= 32'h0;
      pause_q <= 1'b0;
    end
    else
    begin
      if (go)
        {nb_q, fcm_q, rd_q, lane_q, opc_q} <= pwdata[CT_TOP:0];
      if (wr && paddr == A_TXD)
        txd_q <= pwdata;
      if (wr && paddr == A_PAUSE)
        pause_q <= pwdata[0];
    end
  end

  // Reset pin pulse of fixed length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rcnt_q <= '0;
    else if (wr && paddr == A_HWRST && st_q == HS_IDLE)
      rcnt_q <= RW'(HW_RST_CYC);
    else if (rcnt_q != '0)
      rcnt_q <= rcnt_q - 1'b1;
  end

  // Divider held at zero while paused with clock low
  assign tick = div_q == DW'(SCK_HALF - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else if (st_q == HS_IDLE || (pause_q && !sck_q))
      div_q <= '0;
    else
      div_q <= tick ? '0 : div_q + 1'b1;
  end

  assign opcl   = fcm_q ? 6'h2 : 6'h8;
  assign ncl    = opcl + 6'(nb_q) * (6'h8 >> lane_q);
  assign in_dat = ccnt_q >= opcl;
  assign hl     = in_dat ? lane_q : (fcm_q ? LW4 : LW1);

  // Lane synchroniser for read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
    end
    else
    begin
      s1_q <= lnk.io;
      s2_q <= s1_q;
    end
  end

  // Frame engine: mode 0, clock idles low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= HS_IDLE;
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
      ccnt_q <= 6'h0;
      tsh_q  <= 40'h0;
      rxd_q  <= 32'h0;
    end
    else
    begin
      case (st_q)
        HS_IDLE:
        begin
          if (go)
          begin
            st_q   <= HS_SEL;
            cs_n_q <= 1'b0;
            ccnt_q <= 6'h0;
            tsh_q  <= {pwdata[7:0], txd_q};
            rxd_q  <= 32'h0;
          end
        end
        HS_SEL:
          if (tick)
            st_q <= HS_XFER;
        HS_XFER:
        begin
          if (tick && !sck_q)
            sck_q <= 1'b1;
          else if (tick)
          begin
            // Read sample taken just before the fall
            sck_q  <= 1'b0;
            ccnt_q <= ccnt_q + 6'h1;
            tsh_q  <= tsh_q << (6'h1 << hl);
            if (rd_q && in_dat)
            begin
              case (hl)
                LW2:     rxd_q <= {rxd_q[29:0], s2_q[1:0]};
                LW4:     rxd_q <= {rxd_q[27:0], s2_q};
                default: rxd_q <= {rxd_q[30:0], s2_q[1]};
              endcase
            end
            if (ccnt_q == ncl - 6'h1)
              st_q <= HS_END;
          end
        end
        HS_END:
        begin
          // Select high for a full half period before idle
          if (tick && !cs_n_q)
            cs_n_q <= 1'b1;
          else if (tick)
            st_q <= HS_IDLE;
        end
        default:
          st_q <= HS_IDLE;
      endcase
    end
  end

  // Lane drive; spare lanes hold write-protect high and pause on lane 3
  always_comb
  begin
    ho  = {~pause_q, 1'b1, 2'h0};
    hoe = 4'hd;
    case (hl)
      LW2:
      begin
        ho[1:0] = tsh_q[39:38];
        hoe     = (rd_q && in_dat) ? 4'hc : 4'hf;
      end
      LW4:
      begin
        ho  = tsh_q[39:36];
        hoe = (rd_q && in_dat) ? 4'h0 : 4'hf;
      end
      default:
        ho[0] = tsh_q[39];
    endcase
  end

  assign lnk.h_o   = ho;
  assign lnk.h_oe  = hoe;
  assign lnk.sck   = sck_q;
  assign lnk.cs_n  = cs_n_q;
  assign lnk.rst_n = rcnt_q == '0;
endmodule

//--- verification/sfhi_checker.sv
// Timing checks on the flash link and the device's state outputs.
// Assumes one pclk domain; sees only link wires and device state.
`timescale 1ns/1ps
module sfhi_checker
#(
  parameter int RST_CYC = 1200
)
(
  // Clock and reset
  input logic       pclk,
  input logic       presetn,
  // Link wires
  input logic       sck,
  input logic       cs_n,
  input logic       rst_n,
  input logic [3:0] d_oe,
  // Device state
  input logic       quad_lane_enable,
  input logic       four_lane_command_mode,
  input logic       paused,
  input logic       busy,
  input logic       rx_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  int unsigned blen_q;  // Length of the current soft reset wait

  // Count busy cycles; a wait cut short or stretched shows here
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      blen_q <= 0;
    else
      blen_q <= busy ? blen_q + 1 : 0;

  chk_idle_lanes_off: assert property (cs_n [*5] |-> d_oe == 4'h0)
    else $error("device drives a lane while deselected");
  chk_select_clock_low: assert property ($fell(cs_n) || $rose(cs_n) |-> !sck)
    else $error("select edge with clock high");
  chk_pause_lanes_off: assert property (paused [*2] |-> d_oe == 4'h0)
    else $error("device drives a lane while paused");
  chk_pause_needs_clear: assert property (
    quad_lane_enable && $past(quad_lane_enable, 3) |-> !paused)
    else $error("pause taken with four lanes enabled");
  chk_mode_needs_enable: assert property (
    $rose(four_lane_command_mode) |-> quad_lane_enable)
    else $error("four-lane mode entered without enable");
  chk_sreset_mode: assert property ($fell(busy) |-> ##[0:2] !four_lane_command_mode)
    else $error("four-lane mode survives soft reset");
  chk_sreset_length: assert property (
    $fell(busy) |-> blen_q + 1 >= RST_CYC && blen_q <= RST_CYC + 1)
    else $error("soft reset wait has wrong length");
  chk_busy_rx_quiet: assert property (busy && $past(busy, 4) |-> !rx_valid)
    else $error("byte taken during soft reset wait");
  chk_hw_clears: assert property (!rst_n [*4] |=> !four_lane_command_mode && !busy)
    else $error("reset pin left state behind");
  chk_hw_rx_quiet: assert property (!rst_n [*4] |-> !rx_valid)
    else $error("byte taken while reset pin low");

  cover property ($rose(four_lane_command_mode));
  cover property ($rose(paused));
  cover property ($rose(busy));
endmodule

//--- verification/serial_flash_host_interface_tb.sv
// Bench: APB-driven host controller facing the flash front end.
// Assumes package, link interface and both ends compile first.
`timescale 1ns/1ps
module serial_flash_host_interface_tb;
  import sfhi_pkg::*;
  localparam int RC = 200;  // Short soft reset wait keeps the run brief
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        quad_en = 1'b0;  // Quad lane enable bit
  logic        pin_rst = 1'b0;  // Lane 3 acts as reset pin
  logic [7:0]  tx_byte = 8'h00;
  logic        tx_drive = 1'b0;
  logic [7:0]  rx_byte;
  logic        rx_valid, rx_is_opc, tx_taken, qmode, paused, busy;
  logic [7:0]  rxq[$];          // Bytes seen by the device
  logic [31:0] rd;              // Last read data
  logic        err;             // Last error flag
  int          oe_cnt = 0;      // Cycles the device drove a lane
  int          tk_cnt = 0;      // Read bytes taken this frame
  int          op_cnt = 0;      // Opcode bytes seen this frame
  int          fails = 0;
  int          check_count = 0;

  sfhi_if lnk_if();
  always #12.5 pclk = ~pclk;

  sfhi_host sfhi_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk_if.host));
  sfhi_dev #(.RST_CYC(RC)) sfhi_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if.dev),
    .quad_lane_enable(quad_en), .pin_is_reset(pin_rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_is_opc(rx_is_opc), .tx_byte(tx_byte), .tx_drive(tx_drive), .tx_taken(tx_taken),
    .four_lane_command_mode(qmode), .paused(paused), .busy(busy));
  sfhi_checker #(.RST_CYC(RC)) sfhi_checker_inst (.pclk(pclk), .presetn(presetn),
    .sck(lnk_if.sck), .cs_n(lnk_if.cs_n), .rst_n(lnk_if.rst_n), .d_oe(lnk_if.d_oe),
    .quad_lane_enable(quad_en), .four_lane_command_mode(qmode), .paused(paused),
    .busy(busy), .rx_valid(rx_valid));

  // Collect device bytes and lane drive activity
  always @(posedge pclk)
  begin
    if (rx_valid)
      rxq.push_back(rx_byte);
    if (|lnk_if.d_oe)
      oe_cnt++;
    tk_cnt += tx_taken;
    op_cnt += rx_valid & rx_is_opc;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cw(logic [7:0] op, logic [1:0] lw, logic r, logic q,
                                     logic [2:0] nb);
    return {17'h0, nb, q, r, lw, op};
  endfunction

  // Run one frame, optionally paused midway, and wait for its end
  task automatic frame(input logic [31:0] ctrl, input logic [31:0] txd, input logic pz);
    apb(1'b1, A_TXD, txd);
    rxq.delete();
    tk_cnt = 0;
    op_cnt = 0;
    apb(1'b1, A_CTRL, ctrl);
    if (pz)
    begin
      repeat (40) @(posedge pclk);
      apb(1'b1, A_PAUSE, 32'h1);
      repeat (20) @(posedge pclk);
      chk(paused, 1'b1);
      chk(lnk_if.d_oe, 4'h0);
      apb(1'b1, A_PAUSE, 32'h0);
    end
    do apb(1'b0, A_STAT, 32'h0); while (rd[0] !== 1'b0);
    repeat (12) @(posedge pclk);
  endtask

  // Opcode and data byte on one lane, plain and paused
  task automatic t_single();
    frame(cw(8'h9f, LW1, 1'b0, 1'b0, 3'h1), 32'ha5000000, 1'b0);
    chk(rxq.size(), 2);
    chk(rxq[0], 8'h9f);
    chk(rxq[1], 8'ha5);
    chk(op_cnt, 1);
    frame(cw(8'h9f, LW1, 1'b0, 1'b0, 3'h1), 32'ha5000000, 1'b1);
    chk(rxq.size(), 2);
    chk(rxq[1], 8'ha5);
  endtask

  // Reads at one, two and four lanes; quad refused without enable
  task automatic t_reads();
    int n0;
    tx_byte <= 8'h5a;
    tx_drive <= 1'b1;
    frame(cw(8'h0b, LW1, 1'b1, 1'b0, 3'h1), 32'h0, 1'b0);
    apb(1'b0, A_RXD, 32'h0);
    chk(rd, 32'h5a);
    chk(tk_cnt, 2);
    frame(cw(OP_DUAL_OUT, LW2, 1'b1, 1'b0, 3'h2), 32'h0, 1'b0);
    apb(1'b0, A_RXD, 32'h0);
    chk(rd, 32'h5a5a);
    chk(tk_cnt, 3);
    n0 = oe_cnt;
    frame(cw(OP_QUAD_OUT, LW4, 1'b1, 1'b0, 3'h1), 32'h0, 1'b0);
    chk(oe_cnt - n0, 0);
    quad_en <= 1'b1;
    frame(cw(OP_QUAD_OUT, LW4, 1'b1, 1'b0, 3'h1), 32'h0, 1'b0);
    apb(1'b0, A_RXD, 32'h0);
    chk(rd, 32'h5a);
    tx_drive <= 1'b0;
  endtask

  // Four-lane command mode entry, use, soft reset and exit
  task automatic t_mode();
    quad_en <= 1'b0;
    frame(cw(OP_FCM_ENTER, LW1, 1'b0, 1'b0, 3'h0), 32'h0, 1'b0);
    chk(qmode, 1'b0);
    quad_en <= 1'b1;
    frame(cw(OP_FCM_ENTER, LW1, 1'b0, 1'b0, 3'h0), 32'h0, 1'b0);
    chk(qmode, 1'b1);
    frame(cw(8'h9f, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    chk(rxq[0], 8'h9f);
    frame(cw(OP_RST, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    chk(qmode, 1'b1);
    frame(cw(OP_RST_EN, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    frame(cw(OP_RST, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    frame(cw(8'h9f, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    chk(rxq.size(), 0);
    while (busy !== 1'b0) @(posedge pclk);
    chk(qmode, 1'b0);
    frame(cw(OP_FCM_ENTER, LW1, 1'b0, 1'b0, 3'h0), 32'h0, 1'b0);
    frame(cw(OP_FCM_EXIT, LW4, 1'b0, 1'b1, 3'h0), 32'h0, 1'b0);
    chk(qmode, 1'b0);
  endtask

  // Reset pin pulse, then lane 3 as reset, then an unmapped access
  task automatic t_hwrst();
    frame(cw(OP_FCM_ENTER, LW1, 1'b0, 1'b0, 3'h0), 32'h0, 1'b0);
    apb(1'b1, A_HWRST, 32'h1);
    repeat (60) @(posedge pclk);
    chk(qmode, 1'b0);
    frame(cw(OP_FCM_ENTER, LW1, 1'b0, 1'b0, 3'h0), 32'h0, 1'b0);
    quad_en <= 1'b0;
    pin_rst <= 1'b1;
    apb(1'b1, A_PAUSE, 32'h1);
    repeat (60) @(posedge pclk);
    chk(qmode, 1'b0);
    apb(1'b1, A_PAUSE, 32'h0);
    pin_rst <= 1'b0;
    apb(1'b0, 12'h0f0, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic wrap_up();
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #1000000;
    fails++;
    wrap_up();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_single();
    t_reads();
    t_mode();
    t_hwrst();
    wrap_up();
  end
endmodule
